// file: edl_divisor_nv.sv
// Divisor non-volatile copy, reset reload, permanent lock and timebase divider

// Notes on behaviour
// - Two non-volatile bytes hold divisor and lock-disable; reset never alters them.
// - Each system reset copies the non-volatile bytes into the live divisor registers.
// - Non-volatile bytes program or erase like EEPROM only while live lock-disable is 1.
// - New non-volatile values reach live registers only at the next system reset.
// - A stored lock-disable 0 reloads as 0 every reset; lock is permanent.
// - With lock armed, every program or erase of either non-volatile byte is refused.
// - With lock armed, software writes to both live divisor registers are ignored.
// - Non-volatile bits read their programmed value, or 1 when erased.
// - Lock-disable 1 leaves the lock inactive; 0 arms it.
// - Divisor bits always readable; writable only with latch clear and lock-disable 1.
// - The live divisor is 11 bits across a high and a low register.
// - The live divisor divides the reference clock to a roughly 35 us timebase.
module edl_divisor_nv
   import edl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic        ref_clk_tick,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             timebase_tick,
   output logic             lock_armed
);

   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic rst_s1_r;
   logic rst_s2_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire rst_n = rst_s2_r;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // Non-volatile array has no reset branch so it survives every reset
   logic [7:0]  nv_mem [0:1];
   logic [7:0]  div_high_live_r;
   logic [7:0]  div_low_live_r;
   logic        latch_r;
   logic        busy_r;
   logic        op_erase_r;
   logic        op_sel_r;
   logic [7:0]  op_data_r;
   logic [15:0] op_cnt_r;
   logic [10:0] tb_cnt_r;
   logic        rd_valid_r;
   logic [31:0] rdata_r;
   edl_state_t  state_r;

   initial begin
      nv_mem[0] = ERASED_BYTE;
      nv_mem[1] = ERASED_BYTE;
   end

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   wire        lock_dis   = div_high_live_r[BIT_LOCK_DIS];
   wire        running    = (state_r == EDL_RUN);
   wire        wr_hit     = avs_write && running && clk_en;
   wire        sel_hl     = (avs_address == {1'b0, OFS_DIV_HIGH_LIVE});
   wire        sel_ll     = (avs_address == {1'b0, OFS_DIV_LOW_LIVE});
   wire        sel_hn     = (avs_address == {1'b0, OFS_DIV_HIGH_NV});
   wire        sel_ln     = (avs_address == {1'b0, OFS_DIV_LOW_NV});
   wire        sel_ctl    = (avs_address == OFS_CONTROL);
   wire        sel_st     = (avs_address == OFS_STATUS);
   wire        b0         = avs_byteenable[0];
   // Silent refusal: the bus still completes, nothing is stored
   wire        live_wr_ok = lock_dis && !latch_r;
   wire        nv_wr_ok   = lock_dis && latch_r && !busy_r;
   wire        nv_start   = wr_hit && b0 && (sel_hn || sel_ln) && nv_wr_ok;
   wire [10:0] divisor    = {div_high_live_r[HIGH_DIV_BITS-1:0], div_low_live_r};

   assign lock_armed      = !lock_dis;
   // A low clock enable stalls the bus, else a write is acknowledged and lost,
   // and a frozen read-valid would answer the next read with stale data
   wire        bus_stall  = !running || !clk_en;
   // Reads wait one cycle for registered data; writes finish at once
   assign avs_waitrequest = (avs_read && !rd_valid_r) || ((avs_read || avs_write) && bus_stall);
   assign avs_readdata    = rdata_r;

   // -----------------------------------------------------------------
   // Reset reload sequence
   // -----------------------------------------------------------------
   // Only a reset reloads the live copy; later NV programming waits for it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EDL_LOAD_HIGH;
      end else if (clk_en) begin
         unique case (state_r)
            EDL_LOAD_HIGH: state_r <= EDL_LOAD_LOW;
            EDL_LOAD_LOW:  state_r <= EDL_RUN;
            EDL_RUN:       state_r <= EDL_RUN;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Live registers and control
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_high_live_r <= 8'h00;
         div_low_live_r  <= 8'h00;
         latch_r         <= 1'b0;
      end else if (clk_en) begin
         if (state_r == EDL_LOAD_HIGH) begin
            div_high_live_r <= nv_mem[1];
         end else if (state_r == EDL_LOAD_LOW) begin
            div_low_live_r <= nv_mem[0];
         end else if (wr_hit && b0 && live_wr_ok) begin
            if (sel_hl) begin
               div_high_live_r <= avs_writedata[7:0];
            end
            if (sel_ll) begin
               div_low_live_r <= avs_writedata[7:0];
            end
         end
         if (wr_hit && b0 && sel_ctl && !busy_r) begin
            latch_r <= avs_writedata[BIT_LATCH];
         end
      end
   end

   // -----------------------------------------------------------------
   // Non-volatile program / erase engine
   // -----------------------------------------------------------------
   // Program clears bits only (AND), erase returns the byte to all ones
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r     <= 1'b0;
         op_erase_r <= 1'b0;
         op_sel_r   <= 1'b0;
         op_data_r  <= 8'h00;
         op_cnt_r   <= 16'h0000;
      end else if (clk_en) begin
         if (nv_start) begin
            busy_r     <= 1'b1;
            op_erase_r <= avs_writedata[8 + BIT_NV_ERASE];
            op_sel_r   <= sel_hn;
            op_data_r  <= avs_writedata[7:0];
            op_cnt_r   <= 16'(NV_OP_TICKS);
         end else if (busy_r && timebase_tick) begin
            if (op_cnt_r == 16'h0001) begin
               busy_r <= 1'b0;
            end
            op_cnt_r <= op_cnt_r - 16'h0001;
         end
      end
   end

   wire nv_commit = clk_en && busy_r && timebase_tick && (op_cnt_r == 16'h0001);
   always_ff @(posedge sys_clk) begin
      if (nv_commit) begin
         nv_mem[op_sel_r] <= op_erase_r ? ERASED_BYTE : (nv_mem[op_sel_r] & op_data_r);
      end
   end

   // -----------------------------------------------------------------
   // Timebase divider
   // -----------------------------------------------------------------
   // Divisor of zero or one gives a tick every reference edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tb_cnt_r      <= 11'h000;
         timebase_tick <= 1'b0;
      end else if (clk_en) begin
         timebase_tick <= 1'b0;
         if (running && ref_clk_tick) begin
            if (tb_cnt_r + 11'h001 >= divisor) begin
               tb_cnt_r      <= 11'h000;
               timebase_tick <= 1'b1;
            end else begin
               tb_cnt_r <= tb_cnt_r + 11'h001;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   wire [31:0] rd_mux =
      sel_hl  ? {24'h0, div_high_live_r} :
      sel_ll  ? {24'h0, div_low_live_r} :
      sel_hn  ? {24'h0, nv_mem[1]} :
      sel_ln  ? {24'h0, nv_mem[0]} :
      sel_ctl ? {31'h0, latch_r} :
      sel_st  ? {30'h0, !lock_dis, busy_r} : UNMAPPED_RDATA;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_r <= 1'b0;
         rdata_r    <= 32'h0000_0000;
      end else if (clk_en) begin
         rd_valid_r <= avs_read && running && !rd_valid_r;
         if (avs_read && running && !rd_valid_r) begin
            rdata_r <= rd_mux;
         end
      end
   end

endmodule : edl_divisor_nv

// file: edl_pkg.sv
// Package: register map, field layout and timing constants of the divisor reload/lock block
package edl_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // -----------------------------------------------------------------
   localparam logic [3:0] OFS_DIV_HIGH_LIVE = 4'h0;
   localparam logic [3:0] OFS_DIV_LOW_LIVE  = 4'h4;
   localparam logic [3:0] OFS_DIV_HIGH_NV   = 4'h8;
   localparam logic [3:0] OFS_DIV_LOW_NV    = 4'hC;
   localparam logic [3:0] OFS_CTRL          = 4'h0; // Word index space shared below
   localparam logic [4:0] OFS_CONTROL       = 5'h10;
   localparam logic [4:0] OFS_STATUS        = 5'h14;

   // -----------------------------------------------------------------
   // Field layout
   // -----------------------------------------------------------------
   localparam int DIV_WIDTH       = 11;
   localparam int HIGH_DIV_BITS   = 3;
   localparam int BIT_LOCK_DIS    = 7;
   localparam int BIT_LATCH       = 0;
   localparam int BIT_NV_ERASE    = 1;
   localparam int BIT_ST_BUSY     = 0;
   localparam int BIT_ST_ARMED    = 1;

   // -----------------------------------------------------------------
   // Reset and erased values
   // -----------------------------------------------------------------
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
   localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int SYS_CLK_HZ        = 50_000_000;
   localparam int TIMEBASE_NS       = 35_000;
   localparam int TIMEBASE_CYC_NOM  = (TIMEBASE_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
   localparam int NV_OP_MS          = 10;
   localparam int NV_OP_TICKS       = (NV_OP_MS * 1000) / 35;

   typedef enum logic [1:0] {EDL_LOAD_HIGH, EDL_LOAD_LOW, EDL_RUN} edl_state_t;

endpackage : edl_pkg

// file: edl_divisor_nv_chk.sv
// Checker: bus timing and lock relations at the divisor block's ports
module edl_chk
   import edl_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        lock_armed
);
   logic [3:0] up_r;
   // Reload runs a few edges after release, so the lock is judged once settled
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         up_r <= 4'h0;
      else if (up_r != 4'hF)
         up_r <= up_r + 4'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read answered without wait");
   a_read_bound: assert property (avs_read |-> ##[0:8] !avs_waitrequest)
      else $error("read not answered");
   a_write_bound: assert property (avs_write |-> ##[0:8] !avs_waitrequest)
      else $error("write not accepted");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without read");
   a_lock_sticky: assert property (up_r == 4'hF && lock_armed |=> lock_armed)
      else $error("lock released");
   a_unmapped_zero: assert property (s_rd_done ##0 avs_address >= 5'h18 |-> avs_readdata == UNMAPPED_RDATA)
      else $error("unmapped read not zero");
   a_status_armed: assert property (s_rd_done ##0 avs_address == OFS_STATUS |-> avs_readdata[BIT_ST_ARMED] == lock_armed)
      else $error("status armed mismatch");
   a_lock_polarity: assert property (s_rd_done ##0 avs_address == 5'h00 |-> avs_readdata[BIT_LOCK_DIS] != lock_armed)
      else $error("lock bit polarity wrong");
   a_byte_wide: assert property (s_rd_done ##0 avs_address < 5'h10 |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("divisor register wider than byte");
endmodule : edl_chk

bind edl_divisor_nv edl_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lock_armed(lock_armed));

// file: edl_divisor_nv_test.sv
// Testbench: reload, reprogramming and permanent lock of the timebase divisor
module edl_divisor_nv_test import edl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] A_HL = 5'h00, A_LL = 5'h04, A_HN = 5'h08, A_LN = 5'h0C, A_CT = 5'h10;
   logic        sys_clk, rstn, avs_read, avs_write, avs_waitrequest, timebase_tick, lock_armed, ref_tick;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int          failures, n_tests, n;

   edl_divisor_nv u_edl_divisor_nv (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .ref_clk_tick(ref_tick),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timebase_tick(timebase_tick), .lock_armed(lock_armed));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_wr
   // Read data is taken at the same edge that shows waitrequest low
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_rd
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      bus_rd(a, rd);
      chk(rd, exp);
   endtask : rd_chk
   // Polling keeps the next operation off a busy array; busy reads are not mismatches
   task automatic nv_op(input logic [4:0] a, input logic [31:0] d);
      bus_wr(a, d);
      do bus_rd(A_CT + 5'h04, rd); while (rd[BIT_ST_BUSY] !== 1'b0);
   endtask : nv_op
   task automatic do_reset;
      rstn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask : do_reset

   task automatic t_erased;
      rd_chk(A_HL, 32'h0000_00FF);
      rd_chk(A_LL, 32'h0000_00FF);
      chk({31'h0, lock_armed}, 32'h0000_0000);
      $display("erased reload done");
   endtask : t_erased
   task automatic t_live;
      bus_wr(A_LL, 32'h0000_0002);
      bus_wr(A_HL, 32'h0000_0080);
      rd_chk(A_HL, 32'h0000_0080);
      rd_chk(A_LL, 32'h0000_0002);
      n = 0;
      repeat (20) begin
         @(posedge sys_clk);
         n += timebase_tick;
      end
      chk(n, 32'h0000_000A);
      // No reference edges, no timebase: the divider counts reference ticks only
      ref_tick <= 1'b0;
      n = 0;
      @(posedge sys_clk);
      repeat (20) begin
         @(posedge sys_clk);
         n += timebase_tick;
      end
      ref_tick <= 1'b1;
      chk(n, 32'h0000_0000);
      bus_wr(A_CT, 32'h0000_0001);
      bus_wr(A_LL, 32'h0000_0007);
      rd_chk(A_LL, 32'h0000_0002);
      $display("live write done");
   endtask : t_live
   task automatic t_nv;
      nv_op(A_LN, 32'h0000_0005);
      rd_chk(A_LN, 32'h0000_0005);
      nv_op(A_LN, 32'h0000_0200);
      rd_chk(A_LN, 32'h0000_00FF);
      nv_op(A_HN, 32'h0000_0001);
      rd_chk(A_HN, 32'h0000_0001);
      rd_chk(A_HL, 32'h0000_0080);
      bus_wr(A_CT, 32'h0000_0000);
      $display("nv program done");
   endtask : t_nv
   task automatic t_lock;
      do_reset;
      rd_chk(A_HL, 32'h0000_0001);
      rd_chk(A_LL, 32'h0000_00FF);
      chk({31'h0, lock_armed}, 32'h0000_0001);
      bus_wr(A_LL, 32'h0000_0003);
      bus_wr(A_HL, 32'h0000_0080);
      rd_chk(A_LL, 32'h0000_00FF);
      rd_chk(A_HL, 32'h0000_0001);
      bus_wr(A_CT, 32'h0000_0001);
      bus_wr(A_LN, 32'h0000_0000);
      rd_chk(A_CT + 5'h04, 32'h0000_0002);
      rd_chk(A_LN, 32'h0000_00FF);
      rd_chk(5'h18, 32'h0000_0000);
      do_reset;
      rd_chk(A_HL, 32'h0000_0001);
      rd_chk(A_HN, 32'h0000_0001);
      $display("lock done");
   endtask : t_lock

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      conclude;
   end
   initial begin
      rstn = 1'b0;
      ref_tick = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      failures = 0;
      n_tests = 0;
      do_reset;
      t_erased;
      t_live;
      t_nv;
      t_lock;
      conclude;
   end
endmodule : edl_divisor_nv_test
